// ==== bench/adcn_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcn_core (
  // System
  input wire logic       clk_sys,
  input wire logic       nrst,
  // Converter control
  input wire logic [2:0] ain_sel,
  input wire logic       sample_hold
);
  logic [2:0] seen_q[$];
  logic       hold_q;

  // Channel taken at each new sample, so a late done pulse cannot skew it
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) seen_q.delete();
    else if (sample_hold && seen_q.size() < 64 && !hold_q) seen_q.push_back(ain_sel);
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) hold_q <= 1'b0;
    else hold_q <= sample_hold;
  end
endmodule
`default_nettype wire

// ==== bench/adcn_ctrl_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcn_ctrl_chk (
  // System
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        ce,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Core
  input wire logic        sample_hold,
  input wire logic        conv_active,
  input wire logic        vref_en,
  input wire logic        conv_done,
  input wire logic        conv_irq
);
  // ----
  // Phase lengths
  // ----
  logic [15:0] sh_n;
  logic [15:0] ca_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) sh_n <= 16'h0000;
    else sh_n <= sample_hold ? sh_n + 16'h0001 : 16'h0000;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) ca_n <= 16'h0000;
    else ca_n <= conv_active ? ca_n + 16'h0001 : 16'h0000;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
    else $error("pready missing after setup");
  a_start_reads_zero: assert property (pready && !pwrite && paddr == 8'h04 |-> !prdata[0])
    else $error("start bit read back as one");
  a_upper_read_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
    else $error("reserved read bits not zero");
  a_phase_exclusive: assert property (!(sample_hold && conv_active))
    else $error("sample and convert overlap");
  a_sample_min_len: assert property ($fell(sample_hold) |-> sh_n >= 16'h0008)
    else $error("sample phase too short");
  a_conv_min_len: assert property ($fell(conv_active) |-> ca_n >= 16'h0026)
    else $error("conversion phase too short");
  a_conv_after_sample: assert property ($rose(conv_active) |-> $past(sample_hold))
    else $error("conversion without sample");
  a_irq_with_done: assert property (conv_irq |-> conv_done)
    else $error("interrupt without completion");
  a_vref_write: assert property (psel && penable && pready && pwrite && ce &&
      paddr == adcn_pkg::ADDR_INSEL_PWR |-> ##2 vref_en == $past(pwdata[7], 2))
    else $error("reference enable not updated");
endmodule

bind adcn_ctrl adcn_ctrl_chk adcn_ctrl_chk_inst (.clk_sys, .nrst, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .sample_hold, .conv_active, .vref_en, .conv_done, .conv_irq);
`default_nettype wire

// ==== bench/adcn_ctrl_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin bad_count++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module adcn_ctrl_tb;
  logic        clk_sys, nrst, ce, sys_idle, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, sample_hold, conv_active, vref_en, conv_done, conv_irq;
  logic [2:0]  ain_sel;
  logic [15:0] sh_n, sh_w, ca_n, ca_w, dn_n, iq_n;
  int          bad_count, checks;

  adcn_ctrl adcn_ctrl_inst (.clk_sys, .nrst, .ce, .sys_idle, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ain_sel, .sample_hold, .conv_active, .vref_en,
    .conv_done, .conv_irq);
  adcn_core adcn_core_inst (.clk_sys, .nrst, .ain_sel, .sample_hold);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Phase widths and event counts seen at the ports
  always @(posedge clk_sys) begin
    sh_n <= sample_hold ? sh_n + 16'h1 : 16'h0;
    ca_n <= conv_active ? ca_n + 16'h1 : 16'h0;
    if (!sample_hold && sh_n != 16'h0) sh_w <= sh_n;
    if (!conv_active && ca_n != 16'h0) ca_w <= ca_n;
    dn_n <= dn_n + 16'(conv_done);
    iq_n <= iq_n + 16'(conv_irq);
  end

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 100);
    r = prdata;
    err = pslverr;
    if (n >= 100) bad_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_flag(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(8'h04, 1'b0, 32'h0);
      n++;
    end while (r[b] !== v && n < 3000);
    if (r[b] !== v) bad_count++;
  endtask

  task automatic start(input logic [31:0] mode);
    apb(8'h04, 1'b1, mode);
    apb(8'h04, 1'b1, mode | 32'h1);
  endtask

  task automatic conv(input logic [31:0] mode);
    start(mode);
    wait_flag(7, 1'b1);
    // Phase widths settle two edges after the last conversion edge
    repeat (2) @(posedge clk_sys);
    `CHK("done", 1'b1, r[7])
  endtask

  task automatic chans(input logic [3:0] n, input logic [23:0] e);
    logic [23:0] g;
    g = 24'h0;
    foreach (adcn_core_inst.seen_q[i]) g[i*3 +: 3] = adcn_core_inst.seen_q[i];
    `CHK("chan_count", n, 4'(adcn_core_inst.seen_q.size()))
    `CHK("chan_order", e, g)
    adcn_core_inst.seen_q.delete();
  endtask

  // Repeat runs a window of conversions, then drops back to single and idles
  task automatic irqs(input logic [31:0] mode, input logic [15:0] nd, input logic [15:0] ni);
    logic [15:0] d0, i0;
    int n;
    start(mode);
    d0 = dn_n;
    i0 = iq_n;
    n = 0;
    while (dn_n - d0 < nd && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("conv_count", nd, dn_n - d0)
    `CHK("irq_count", ni, iq_n - i0)
    apb(8'h04, 1'b1, 32'h0);
    wait_flag(6, 1'b0);
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    apb(8'h00, 1'b0, 32'h0);
    `CHK("clk_set", 32'h0000_0080, r)
    apb(8'h04, 1'b0, 32'h0);
    `CHK("mode", 32'h0, r)
    apb(8'h08, 1'b0, 32'h0);
    `CHK("insel", 32'h0, r)
    apb(8'h0C, 1'b0, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask

  task automatic t_single();
    apb(8'h08, 1'b1, 32'h0000_0085);
    repeat (75) @(posedge clk_sys);
    `CHK("vref_on", 1'b1, vref_en)
    start(32'h0);
    apb(8'h04, 1'b0, 32'h0);
    `CHK("busy", 3'h2, r[7:5])
    `CHK("start_rd", 1'b0, r[0])
    wait_flag(7, 1'b1);
    `CHK("stopped", 1'b0, r[6])
    apb(8'h04, 1'b0, 32'h0);
    `CHK("done_clr", 1'b0, r[7])
    chans(4'h1, 24'h5);
  endtask

  task automatic t_scan();
    apb(8'h08, 1'b1, 32'h0000_0086);
    conv(32'h2);
    chans(4'h3, 24'({3'h6, 3'h5, 3'h4}));
    apb(8'h08, 1'b1, 32'h0000_00A2);
    conv(32'h2);
    chans(4'h3, 24'({3'h2, 3'h1, 3'h0}));
  endtask

  task automatic t_repeat();
    apb(8'h08, 1'b1, 32'h0000_0083);
    for (int k = 0; k < 3; k++) begin
      irqs(32'(8 * k + 4), 16'h8, 16'(k == 0 ? 8 : 3 - k));
    end
    apb(8'h08, 1'b1, 32'h0000_0081);
    irqs(32'h0000_000E, 16'h4, 16'h2);
  endtask

  task automatic t_idle();
    logic [15:0] d0;
    apb(8'h08, 1'b1, 32'h0000_0082);
    sys_idle <= 1'b1;
    start(32'h0);
    d0 = dn_n;
    repeat (200) @(posedge clk_sys);
    `CHK("idle_stop", d0, dn_n)
    sys_idle <= 1'b0;
    wait_flag(7, 1'b1);
    apb(8'h08, 1'b1, 32'h0000_00C2);
    sys_idle <= 1'b1;
    conv(32'h0);
    sys_idle <= 1'b0;
  endtask

  task automatic t_timing();
    logic [3:0] tsh [7] = '{4'h8, 4'h9, 4'hA, 4'hB, 4'h3, 4'hC, 4'hD};
    int         shc [7] = '{8, 16, 24, 32, 64, 128, 512};
    for (int i = 0; i < 7; i++) begin
      apb(8'h00, 1'b1, {24'h0, tsh[i], 4'h0});
      conv(32'h0);
      `CHK("sample_len", 16'(shc[i]), sh_w)
      `CHK("conv_len", 16'h26, ca_w)
    end
    for (int d = 0; d < 5; d++) begin
      apb(8'h00, 1'b1, 32'(8'h80 + d));
      conv(32'h0);
      `CHK("div_sample", 16'(8 << d), sh_w)
      `CHK("div_conv", 16'(38 << d), ca_w)
    end
    apb(8'h08, 1'b1, 32'h0);
    repeat (2) @(posedge clk_sys);
    `CHK("vref_off", 1'b0, vref_en)
  endtask

  task automatic results();
    $display("Mismatches %0d, comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    nrst      = 1'b0;
    ce        = 1'b1;
    sys_idle  = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0;
    {sh_n, ca_n, dn_n, iq_n} = 64'h0;
    bad_count = 0;
    checks    = 0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_single();
    t_scan();
    t_repeat();
    t_idle();
    t_timing();
    results();
  end

  // Whole run needs about 5000 cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    results();
  end
endmodule
`default_nettype wire

// ==== hw/adcn_clk_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module adcn_clk_div (
  // System
  input  wire logic  clk_sys,
  input  wire logic  nrst,
  input  wire logic  ce,
  // Tick
  adcn_tick_if.src   tk
);
  logic [3:0] cnt_r;
  logic [3:0] lim;

  // -----------------------------------------------------------------
  // Divider fc, fc/2 .. fc/16
  // -----------------------------------------------------------------
  always_comb begin
    case (tk.sel)
      3'h0:    lim = 4'h0;
      3'h1:    lim = 4'h1;
      3'h2:    lim = 4'h3;
      3'h3:    lim = 4'h7;
      default: lim = 4'hF;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
    end else if (ce) begin
      if (!tk.run || cnt_r >= lim) begin
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  assign tk.tick = tk.run && (cnt_r >= lim);
endmodule
`default_nettype wire

// ==== hw/adcn_ctrl.sv ====
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: Start bit launches conversion, reads zero
// RL2: Done flag set when conversion completes
// RL3: Reading done flag clears it
// RL4: Busy flag high during conversion
// RL5: Repeat bit picks single or continuous
// RL6: Scan bit picks fixed or scan
// RL7: Interval field: interrupt every 1/4/8
// RL8: Interval only in fixed repeat mode
// RL9: Scan width bit picks 4 or 8
// RL10: Channel field selects fixed input
// RL11: Scan ranges per channel code
// RL12: Idle bit keeps converter running in IDLE
// RL13: Software waits reference settle before start
// RL14: Software clears reference after completion
// RL15: Software keeps clock selection during conversion
// RL16: Software sets mode before start
// RL17: Software DMA setup ordering
// RL18: Sample-hold field sets sampling clocks
// RL19: Clock select divides system clock
// RL20: Conversion is sample plus 38 clocks
// RL21: Scan ascends, completion after last channel
module adcn_ctrl (
  // System
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        sys_idle,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Analog core
  output logic [2:0]       ain_sel,
  output logic             sample_hold,
  output logic             conv_active,
  output logic             vref_en,
  output logic             conv_done,
  output logic             conv_irq
);
  logic [7:0]  clk_set_r;
  logic [4:0]  mode_r;
  logic [7:0]  insel_r;
  logic        done_r;
  logic        busy_r;
  logic        start_r;
  logic [2:0]  ch_r;
  logic [9:0]  cnt_r;
  logic [3:0]  rep_cnt_r;
  adcn_pkg::adcn_state_t st_r;
  logic        wr_en;
  logic        rd_en;
  logic        rd_done;
  logic        finish;
  logic        pass_end;
  logic        irq_ev;
  logic        run_ok;
  logic [2:0]  first_ch;
  logic [2:0]  last_ch;
  logic [9:0]  sh_clks;
  adcn_tick_if tk ();

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [9:0] sh_count(input logic [3:0] code);
    case (code)
      4'h8:    sh_count = adcn_pkg::SH_8;
      4'h9:    sh_count = adcn_pkg::SH_16;
      4'hA:    sh_count = adcn_pkg::SH_24;
      4'hB:    sh_count = adcn_pkg::SH_32;
      4'h3:    sh_count = adcn_pkg::SH_64;
      4'hC:    sh_count = adcn_pkg::SH_128;
      4'hD:    sh_count = adcn_pkg::SH_512;
      default: sh_count = adcn_pkg::SH_8;
    endcase
  endfunction

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  assign wr_en = psel && penable && pwrite && ce;
  assign rd_en = psel && penable && !pwrite && ce;
  assign rd_done = rd_en && (paddr == adcn_pkg::ADDR_MODE_CTRL);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == adcn_pkg::ADDR_CLK_SET) begin
          prdata <= {24'h000000, clk_set_r};
        end else if (paddr == adcn_pkg::ADDR_MODE_CTRL) begin
          prdata <= {24'h000000, done_r, busy_r, 1'b0, mode_r[4:1], 1'b0}; // [RL1] [RL2] [RL4]
        end else if (paddr == adcn_pkg::ADDR_INSEL_PWR) begin
          prdata <= {24'h000000, insel_r};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      clk_set_r <= adcn_pkg::CLK_SET_RST;
      mode_r    <= adcn_pkg::MODE_CTRL_RST[4:0];
      insel_r   <= adcn_pkg::INSEL_PWR_RST;
    end else if (wr_en) begin
      if (paddr == adcn_pkg::ADDR_CLK_SET) begin
        clk_set_r <= {pwdata[7:4], 1'b0, pwdata[2:0]};
      end else if (paddr == adcn_pkg::ADDR_MODE_CTRL) begin
        mode_r <= {pwdata[4:1], 1'b0};
      end else if (paddr == adcn_pkg::ADDR_INSEL_PWR) begin
        insel_r <= {pwdata[7:5], 1'b0, pwdata[3:0]};
      end
    end
  end

  // Start is a pulse only, never stored as readable state
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_r <= 1'b0;
    end else if (ce) begin
      start_r <= wr_en && (paddr == adcn_pkg::ADDR_MODE_CTRL) && !busy_r
                 && pwdata[adcn_pkg::START_BIT]; // [RL1]
    end
  end

  // -----------------------------------------------------------------
  // Channel range
  // -----------------------------------------------------------------
  always_comb begin
    last_ch  = insel_r[2:0];
    first_ch = 3'h0;
    if (mode_r[adcn_pkg::SCAN_BIT] && !insel_r[adcn_pkg::SCNW_BIT]) begin
      first_ch = {insel_r[2], 2'b00}; // [RL11] [RL9]
    end
  end

  assign sh_clks  = sh_count(clk_set_r[7:4]); // [RL18]
  assign run_ok   = !sys_idle || insel_r[adcn_pkg::IDLE_BIT]; // [RL12]
  assign finish   = (st_r == adcn_pkg::ST_CONV) && tk.tick && (cnt_r == 10'h000);
  // Reserved channel codes (bit 3 set) fall back to the low three bits
  assign pass_end = !mode_r[adcn_pkg::SCAN_BIT] || (ch_r == last_ch); // [RL21] [RL10]
  assign tk.sel   = clk_set_r[2:0]; // [RL19]
  assign tk.run   = busy_r && run_ok;

  adcn_clk_div u_div (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .tk      (tk)
  );

  // -----------------------------------------------------------------
  // Conversion sequencer
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_r   <= adcn_pkg::ST_IDLE;
      busy_r <= 1'b0;
      cnt_r  <= 10'h000;
      ch_r   <= 3'h0;
    end else if (ce) begin
      case (st_r)
        adcn_pkg::ST_IDLE: begin
          if (start_r) begin
            st_r   <= adcn_pkg::ST_SAMPLE;
            busy_r <= 1'b1; // [RL4]
            ch_r   <= mode_r[adcn_pkg::SCAN_BIT] ? first_ch : insel_r[2:0]; // [RL6] [RL10]
            cnt_r  <= sh_clks - 10'h001;
          end
        end
        adcn_pkg::ST_SAMPLE: begin
          if (tk.tick) begin
            if (cnt_r == 10'h000) begin
              st_r  <= adcn_pkg::ST_CONV;
              cnt_r <= adcn_pkg::CONV_TAIL_CLKS - 10'h001; // [RL20]
            end else begin
              cnt_r <= cnt_r - 10'h001;
            end
          end
        end
        adcn_pkg::ST_CONV: begin
          if (tk.tick) begin
            if (cnt_r != 10'h000) begin
              cnt_r <= cnt_r - 10'h001;
            end else if (!pass_end) begin
              ch_r  <= ch_r + 3'h1; // [RL21]
              st_r  <= adcn_pkg::ST_SAMPLE;
              cnt_r <= sh_clks - 10'h001;
            end else if (mode_r[adcn_pkg::REPEAT_BIT]) begin
              ch_r  <= mode_r[adcn_pkg::SCAN_BIT] ? first_ch : insel_r[2:0]; // [RL5]
              st_r  <= adcn_pkg::ST_SAMPLE;
              cnt_r <= sh_clks - 10'h001;
            end else begin
              st_r   <= adcn_pkg::ST_IDLE; // [RL5]
              busy_r <= 1'b0; // [RL4]
            end
          end
        end
        default: begin
          st_r   <= adcn_pkg::ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Completion and interrupt decimation
  // -----------------------------------------------------------------
  always_comb begin
    irq_ev = finish && pass_end;
    if (mode_r[adcn_pkg::REPEAT_BIT] && !mode_r[adcn_pkg::SCAN_BIT]) begin // [RL8]
      case (mode_r[4:3])
        2'b01:   irq_ev = finish && (rep_cnt_r == adcn_pkg::ITV_4 - 4'h1); // [RL7]
        2'b10:   irq_ev = finish && (rep_cnt_r == adcn_pkg::ITV_8 - 4'h1); // [RL7]
        default: irq_ev = finish; // [RL7]
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rep_cnt_r <= 4'h0;
    end else if (ce) begin
      if (start_r || irq_ev) begin
        rep_cnt_r <= 4'h0;
      end else if (finish) begin
        rep_cnt_r <= rep_cnt_r + 4'h1;
      end
    end
  end

  // Set beats read-clear; a read clears only a flag it returned,
  // so a completion landing between setup and access is not lost
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      done_r <= 1'b0;
    end else if (ce) begin
      if (irq_ev) begin
        done_r <= 1'b1; // [RL2]
      end else if (start_r || (rd_done && prdata[adcn_pkg::DONE_BIT])) begin
        done_r <= 1'b0; // [RL3] [RL2]
      end
    end
  end

  // -----------------------------------------------------------------
  // Core outputs
  // -----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ain_sel     <= 3'h0;
      sample_hold <= 1'b0;
      conv_active <= 1'b0;
      vref_en     <= 1'b0;
      conv_done   <= 1'b0;
      conv_irq    <= 1'b0;
    end else if (ce) begin
      ain_sel     <= ch_r;
      sample_hold <= (st_r == adcn_pkg::ST_SAMPLE);
      conv_active <= (st_r == adcn_pkg::ST_CONV);
      vref_en     <= insel_r[adcn_pkg::VREF_BIT]; // [RL13] [RL14]
      conv_done   <= finish;
      conv_irq    <= irq_ev; // [RL7]
    end
  end
endmodule
`default_nettype wire

// ==== hw/adcn_pkg.sv ====
package adcn_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CLK_SET   = 8'h00;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;
  localparam logic [7:0] ADDR_INSEL_PWR = 8'h08;

  // Mode control field positions
  localparam int START_BIT  = 0;
  localparam int SCAN_BIT   = 1;
  localparam int REPEAT_BIT = 2;
  localparam int ITM_LSB    = 3;
  localparam int BUSY_BIT   = 6;
  localparam int DONE_BIT   = 7;

  // Input select field positions
  localparam int CH_LSB     = 0;
  localparam int SCNW_BIT   = 5;
  localparam int IDLE_BIT   = 6;
  localparam int VREF_BIT   = 7;

  // Clock setting field positions
  localparam int CKSEL_LSB  = 0;
  localparam int TSH_LSB    = 4;

  // Reset values
  localparam logic [7:0] CLK_SET_RST   = 8'h80;
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] INSEL_PWR_RST = 8'h00;

  // Timing counts in conversion clocks
  localparam logic [9:0] CONV_TAIL_CLKS = 10'h026;
  localparam logic [9:0] SH_8   = 10'h008;
  localparam logic [9:0] SH_16  = 10'h010;
  localparam logic [9:0] SH_24  = 10'h018;
  localparam logic [9:0] SH_32  = 10'h020;
  localparam logic [9:0] SH_64  = 10'h040;
  localparam logic [9:0] SH_128 = 10'h080;
  localparam logic [9:0] SH_512 = 10'h200;

  // Interrupt intervals
  localparam logic [3:0] ITV_4 = 4'h4;
  localparam logic [3:0] ITV_8 = 4'h8;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } adcn_state_t;
endpackage

// ==== hw/adcn_tick_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface adcn_tick_if;
  logic [2:0] sel;
  logic       run;
  logic       tick;
  modport src (input sel, input run, output tick);
  modport dst (output sel, output run, input tick);
endinterface
`default_nettype wire
